// ===== hdl/nand_host_pkg.sv
package nand_host_pkg;

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int CLK_MHZ     = 20;
   localparam int CLK_NS      = 50;
   localparam int RST_TMO_US  = 1000;                // longest reset busy
   localparam int RST_TMO_DEF = RST_TMO_US * CLK_MHZ; // exact product, 1ms in clock cycles
   localparam int TWB_NS      = 100;                  // we high to busy
   localparam int TWHR_NS     = 60;                   // we high to re low
   localparam int SYNC_CYC    = 2;                    // pin synchroniser lag
   localparam int TWB_CYC     = (TWB_NS + CLK_NS - 1) / CLK_NS;
   localparam int TWHR_CYC    = (TWHR_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [11:0] WB_WAIT  = 12'(TWB_CYC + SYNC_CYC - 1);
   localparam logic [11:0] WHR_WAIT = 12'(TWHR_CYC + SYNC_CYC - 1);

   // ----------------------------------------------------------------------
   // command and address bytes
   // ----------------------------------------------------------------------
   localparam logic [7:0] C_READ       = 8'h00;
   localparam logic [7:0] C_READ_GO    = 8'h30;
   localparam logic [7:0] C_READ_MV    = 8'h35;
   localparam logic [7:0] C_RAND       = 8'h06;
   localparam logic [7:0] C_RAND_GO    = 8'he0;
   localparam logic [7:0] C_PROG       = 8'h80;
   localparam logic [7:0] C_PROG_MV    = 8'h85;
   localparam logic [7:0] C_PLANE_NXT  = 8'h11;
   localparam logic [7:0] C_PROG_GO    = 8'h10;
   localparam logic [7:0] C_PROG_CACHE = 8'h15;
   localparam logic [7:0] C_ERASE      = 8'h60;
   localparam logic [7:0] C_ERASE_NXT  = 8'hd1;
   localparam logic [7:0] C_ERASE_GO   = 8'hd0;
   localparam logic [7:0] C_RESET      = 8'hff;
   localparam logic [7:0] C_ID         = 8'h90;
   localparam logic [7:0] ID_ADR_MAIN  = 8'h00;
   localparam logic [7:0] ID_ADR_SIG   = 8'h20;
   localparam logic [11:0] ID_MAIN_LEN = 12'h005;
   localparam logic [11:0] ID_SIG_LEN  = 12'h004;

   // ----------------------------------------------------------------------
   // sequence layout
   // ----------------------------------------------------------------------
   localparam logic [2:0] ADDR_CYC_FULL = 3'h5;
   localparam logic [2:0] ADDR_CYC_ROW  = 3'h3;
   localparam logic [2:0] ADDR_CYC_ID   = 3'h1;
   localparam logic [2:0] ROW_OFS       = 3'h2;  // erase sends row bytes
   localparam int         PLANE_BIT     = 22;    // plane select in address
   localparam logic [2:0] STAGE_DONE    = 3'h4;
   localparam logic [1:0] PH_WR_LAST    = 2'h2;
   localparam logic [1:0] PH_RD_LAST    = 2'h3;

   // ----------------------------------------------------------------------
   // types
   // ----------------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_RESET, OP_ID_MAIN, OP_ID_SIG, OP_RD2, OP_RD2_MV, OP_RAND2,
      OP_PG2, OP_PG2_CACHE, OP_PG2_MV, OP_ER2, OP_ER2_NOD1
   } op_t;

   typedef enum logic [3:0] {
      S_IDLE, S_PRE, S_CMD, S_ADDR, S_DATA, S_WB, S_BUSY, S_WHR, S_RD
   } fsm_t;

   typedef struct packed {
      op_t         op;
      logic [39:0] addr0;      // first plane, byte 0 in bits 7:0
      logic [39:0] addr1;      // second plane
      logic [11:0] rd_len;     // random read length, 0 means 4096
      logic        with_data;  // move program carries new data
   } req_t;

   typedef struct packed {
      logic       ce_n;
      logic       cle;
      logic       ale;
      logic       we_n;
      logic       re_n;
      logic       wp_n;
      logic       io_oe;
      logic [7:0] io_out;
   } pins_t;

   typedef struct packed {
      fsm_t        fsm;
      req_t        req;
      logic [2:0]  stage;
      logic [11:0] cnt;
      logic [1:0]  ph;
      logic [15:0] tmr;
      pins_t       pins;
      logic [7:0]  rd_data;
      logic        rd_valid;
      logic        done;
      logic        rej;
      logic        tmo;
      logic        init_done;
      logic        rd2_done;
      logic        mv_ok;
      logic [1:0]  mv_plane;
      logic        id_mode;
   } st_t;

   typedef struct packed {
      logic [8:0] s1;
      logic [8:0] s2;
   } sync_t;

   localparam pins_t PINS_RST = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
                                  1'b0, 8'h00};
   localparam st_t ST_RST = '{S_CMD, '{OP_RESET, 40'h0, 40'h0, 12'h000,
                              1'b0}, 3'h0, 12'h000, 2'h0, 16'h0000,
                              PINS_RST, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0,
                              1'b0, 1'b0, 1'b0, 2'h0, 1'b0};
   localparam sync_t SYNC_RST = '{9'h000, 9'h000};

endpackage : nand_host_pkg

// ===== hdl/nand_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module nand_pin_sync
   import nand_host_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       sys_rst_i,
   input  wire logic [8:0] pin_i,
   output logic      [8:0] pin_o
);

   sync_t st_r;
   sync_t st_nxt;

   // two stages; only the second is read outside
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pin_i;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= SYNC_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pin_o = st_r.s2;

endmodule : nand_pin_sync
`default_nettype wire

// ===== hdl/nand_two_plane_host.sv
// Summary of operation
// R1: two-plane read is 00h+5 addr, 00h+5 addr, 30h or 35h; never while busy
// R2: move program planes must match the planes of the move read
// R3: move read confirms with 35h, leaving both pages held inside
// R4: random read 06h+5 addr+E0h only after a completed two-plane read
// R5: move program is 85h+addr+data, 11h, 85h+addr+data, then 10h; the data bytes go out only when with_data is set
// R6: two-plane program 80h..11h-80h..10h; cache variant confirms with 15h
// R7: two-plane erase 60h+3 addr, D1h optional, 60h+3 addr, D0h
// R8: two-plane sequences refused while internal error correction is on
// R9: FFh aborts any sequence in progress in the device
// R10: reset may be sent while the device is busy, aborting it
// R11: after reset the device data and cache contents count as invalid; on reset timeout rd2_done and mv_ok keep their values
// R12: device status after reset is E0h or 60h by write protect
// R13: after FFh ready/busy goes low, then returns high
// R14: reset is the first command after power-on
// R15: reset busy lasts at most 1ms; wait is timed out after that
// R16: identifier read only when the device is idle
// R17: identifier mode stays until another valid command is issued
// R18: identifier with address 00h returns five bytes
// R19: identifier with address 20h returns the four-byte signature
`timescale 1ns/1ps
`default_nettype none
module nand_two_plane_host
   import nand_host_pkg::*;
#(
   parameter int unsigned RST_TMO_CYC = RST_TMO_DEF
)(
   input  wire logic       mclk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       req_valid_i,
   input  wire req_t       req_i,
   output logic            req_ready_o,
   input  wire logic       ecc_en_i,
   input  wire logic       wr_protect_i,
   input  wire logic [7:0] wr_data_i,
   input  wire logic       wr_valid_i,
   input  wire logic       wr_last_i,
   output logic            wr_ready_o,
   output logic      [7:0] rd_data_o,
   output logic            rd_valid_o,
   output logic            done_o,
   output logic            rej_o,
   output logic            tmo_o,
   output logic            init_done_o,
   output logic            id_mode_o,
   output var pins_t       nand_pins_o,
   input  wire logic [7:0] io_i,
   input  wire logic       rdy_busy_n_i
);

   // ----------------------------------------------------------------------
   // sequence tables
   // ----------------------------------------------------------------------
   // command byte of a stage, bit 8 set when the stage has one
   function automatic logic [8:0] seq_cmd(op_t op, logic [2:0] st);
      logic [8:0] r;
      logic       pl;
      r  = 9'h000;
      pl = (st == 3'h0) || (st == 3'h2);
      case (op)
         OP_RESET:    if (st == 3'h0) r = {1'b1, C_RESET};
         OP_ID_MAIN,
         OP_ID_SIG:   if (st == 3'h0) r = {1'b1, C_ID};
         OP_RD2,
         OP_RD2_MV: begin
            if (pl) r = {1'b1, C_READ};
            else if (st == 3'h3)                              // [R1] [R3]
               r = {1'b1, (op == OP_RD2) ? C_READ_GO : C_READ_MV};
         end
         OP_RAND2: begin
            if (st == 3'h0) r = {1'b1, C_RAND};               // [R4]
            else if (st == 3'h3) r = {1'b1, C_RAND_GO};
         end
         OP_PG2,
         OP_PG2_CACHE,
         OP_PG2_MV: begin
            if (pl)                                           // [R5] [R6]
               r = {1'b1, (op == OP_PG2_MV) ? C_PROG_MV : C_PROG};
            else if (st == 3'h1) r = {1'b1, C_PLANE_NXT};
            else if (st == 3'h3)
               r = {1'b1, (op == OP_PG2_CACHE) ? C_PROG_CACHE : C_PROG_GO};
         end
         OP_ER2,
         OP_ER2_NOD1: begin
            if (pl) r = {1'b1, C_ERASE};
            else if (st == 3'h1 && op == OP_ER2)              // [R7]
               r = {1'b1, C_ERASE_NXT};
            else if (st == 3'h3) r = {1'b1, C_ERASE_GO};
         end
         default:     r = 9'h000;
      endcase
      return r;
   endfunction : seq_cmd

   function automatic logic [2:0] addr_n(op_t op, logic [2:0] st);
      logic [2:0] r;
      r = 3'h0;
      if (st == 3'h0 || st == 3'h2) begin
         case (op)
            OP_RESET:              r = 3'h0;
            OP_ID_MAIN, OP_ID_SIG: r = ADDR_CYC_ID;
            OP_ER2, OP_ER2_NOD1:   r = ADDR_CYC_ROW;
            default:               r = ADDR_CYC_FULL;
         endcase
      end
      return r;
   endfunction : addr_n

   function automatic logic is_id(op_t op);
      return (op == OP_ID_MAIN) || (op == OP_ID_SIG);
   endfunction : is_id

   function automatic logic two_plane(op_t op);
      return (op != OP_RESET) && !is_id(op);
   endfunction : two_plane

   // next stage with a command, or STAGE_DONE; then the tail of the op
   function automatic st_t advance(st_t s);
      logic [2:0] ns;
      logic [8:0] c;
      ns = STAGE_DONE;
      for (int i = 3; i >= 1; i--) begin
         c = seq_cmd(s.req.op, 3'(i));
         if (3'(i) > s.stage && c[8]) ns = 3'(i);
      end
      s.cnt = 12'h000;
      s.ph  = 2'h0;
      if (ns != STAGE_DONE) begin
         s.stage = ns;
         s.fsm   = S_CMD;
      end else begin
         s.pins.io_oe = 1'b0;
         s.fsm = (is_id(s.req.op) || s.req.op == OP_RAND2) ? S_WHR : S_WB;
      end
      return s;
   endfunction : advance

   // ----------------------------------------------------------------------
   // pin inputs and request checks
   // ----------------------------------------------------------------------
   st_t         st_r;
   st_t         st_nxt;
   logic [8:0]  pins_s;
   logic        rdy;
   logic        refuse;
   logic        issue;
   logic [2:0]  na;
   logic [8:0]  cmd;
   logic [2:0]  aidx;
   logic [39:0] aword;
   logic [7:0]  abyte;
   logic [11:0] rlen;

   nand_pin_sync u_sync (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     ({rdy_busy_n_i, io_i}),
      .pin_o     (pins_s)
   );

   assign rdy = pins_s[8];

   // a refused request only pulses rej, leaving the device and the other flags untouched
   assign refuse =
      (!st_r.init_done && req_i.op != OP_RESET) ||                // [R14]
      (two_plane(req_i.op) && ecc_en_i) ||                        // [R8]
      (req_i.op == OP_RAND2 && !st_r.rd2_done) ||                 // [R4]
      (is_id(req_i.op) && !rdy) ||                                // [R16]
      (req_i.op == OP_PG2_MV && (!st_r.mv_ok ||                   // [R2]
         {req_i.addr1[PLANE_BIT], req_i.addr0[PLANE_BIT]} != st_r.mv_plane));

   assign issue = (st_r.fsm == S_IDLE) && req_valid_i && !refuse;

   // address byte for the current cycle
   assign na    = addr_n(st_r.req.op, st_r.stage);
   assign cmd   = seq_cmd(st_r.req.op, st_r.stage);
   assign aidx  = st_r.cnt[2:0] + ((na == ADDR_CYC_ROW) ? ROW_OFS : 3'h0);
   assign aword = (st_r.stage == 3'h0) ? st_r.req.addr0 : st_r.req.addr1;
   assign abyte = (st_r.req.op == OP_ID_MAIN) ? ID_ADR_MAIN :   // [R18]
                  (st_r.req.op == OP_ID_SIG)  ? ID_ADR_SIG  :   // [R19]
                  aword[{aidx, 3'b000} +: 8];
   assign rlen  = (st_r.req.op == OP_ID_MAIN) ? ID_MAIN_LEN :
                  (st_r.req.op == OP_ID_SIG)  ? ID_SIG_LEN  :
                  st_r.req.rd_len;

   // ----------------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt           = st_r;
      st_nxt.rd_valid  = 1'b0;
      st_nxt.done      = 1'b0;
      st_nxt.rej       = 1'b0;
      st_nxt.tmo       = 1'b0;
      st_nxt.pins.wp_n = ~wr_protect_i;                           // [R12]
      case (st_r.fsm)
         S_IDLE: begin
            if (req_valid_i && refuse) begin
               st_nxt.rej = 1'b1;
            end else if (req_valid_i) begin
               st_nxt.req     = req_i;
               st_nxt.stage   = 3'h0;
               st_nxt.ph      = 2'h0;
               st_nxt.cnt     = 12'h000;
               st_nxt.id_mode = is_id(req_i.op);                  // [R17]
               // reset goes out even over a busy device
               st_nxt.fsm = (req_i.op != OP_RESET && !rdy) ?      // [R10]
                            S_PRE : S_CMD;
            end
         end
         S_PRE: if (rdy) st_nxt.fsm = S_CMD;                      // [R1]
         S_CMD: begin
            if (st_r.ph == 2'h0) begin
               st_nxt.pins.cle    = 1'b1;
               st_nxt.pins.ale    = 1'b0;
               st_nxt.pins.io_oe  = 1'b1;
               st_nxt.pins.io_out = cmd[7:0];                     // [R9]
               st_nxt.pins.we_n   = 1'b0;
               st_nxt.ph          = 2'h1;
            end else if (st_r.ph == 2'h1) begin
               st_nxt.pins.we_n = 1'b1;
               st_nxt.ph        = PH_WR_LAST;
            end else begin
               st_nxt.pins.cle = 1'b0;
               st_nxt.ph       = 2'h0;
               st_nxt.cnt      = 12'h000;
               if (na != 3'h0) st_nxt.fsm = S_ADDR;
               else st_nxt = advance(st_nxt);
            end
         end
         S_ADDR: begin
            if (st_r.ph == 2'h0) begin
               st_nxt.pins.ale    = 1'b1;
               st_nxt.pins.io_out = abyte;
               st_nxt.pins.we_n   = 1'b0;
               st_nxt.ph          = 2'h1;
            end else if (st_r.ph == 2'h1) begin
               st_nxt.pins.we_n = 1'b1;
               st_nxt.ph        = PH_WR_LAST;
            end else begin
               st_nxt.ph  = 2'h0;
               st_nxt.cnt = st_r.cnt + 12'h001;
               if (st_r.cnt[2:0] == na - 3'h1) begin
                  st_nxt.pins.ale = 1'b0;
                  st_nxt.cnt      = 12'h000;
                  if (st_r.req.op == OP_PG2 || st_r.req.op == OP_PG2_CACHE ||
                      (st_r.req.op == OP_PG2_MV && st_r.req.with_data))
                     st_nxt.fsm = S_DATA;                         // [R5] [R6]
                  else
                     st_nxt = advance(st_nxt);
               end
            end
         end
         S_DATA: begin
            if (st_r.ph == 2'h0) begin
               if (wr_valid_i) begin
                  st_nxt.pins.io_out = wr_data_i;
                  st_nxt.pins.we_n   = 1'b0;
                  st_nxt.cnt         = {11'h000, wr_last_i};
                  st_nxt.ph          = 2'h1;
               end
            end else if (st_r.ph == 2'h1) begin
               st_nxt.pins.we_n = 1'b1;
               st_nxt.ph        = PH_WR_LAST;
            end else begin
               st_nxt.ph = 2'h0;
               if (st_r.cnt[0]) st_nxt = advance(st_nxt);
            end
         end
         S_WB: begin
            st_nxt.cnt = st_r.cnt + 12'h001;
            if (st_r.cnt == WB_WAIT) begin
               st_nxt.fsm = S_BUSY;
               st_nxt.tmr = 16'h0000;
            end
         end
         S_BUSY: begin
            st_nxt.tmr = st_r.tmr + 16'h0001;
            if (rdy) begin                                        // [R13]
               st_nxt.done     = 1'b1;
               st_nxt.fsm      = S_IDLE;
               st_nxt.rd2_done = (st_r.req.op == OP_RD2);
               st_nxt.mv_ok    = (st_r.req.op == OP_RD2_MV);      // [R3]
               st_nxt.mv_plane = {st_r.req.addr1[PLANE_BIT],
                                  st_r.req.addr0[PLANE_BIT]};
               // reset empties the registers, so nothing stays readable
               if (st_r.req.op == OP_RESET)                       // [R11]
                  st_nxt.init_done = 1'b1;                        // [R14]
            end else if (st_r.req.op == OP_RESET &&
                         st_r.tmr == 16'(RST_TMO_CYC - 1)) begin  // [R15]
               st_nxt.tmo = 1'b1;
               st_nxt.fsm = S_IDLE;
            end
         end
         S_WHR: begin
            st_nxt.cnt = st_r.cnt + 12'h001;
            if (st_r.cnt == WHR_WAIT) begin
               st_nxt.fsm = S_RD;
               st_nxt.cnt = 12'h000;
               st_nxt.ph  = 2'h0;
            end
         end
         S_RD: begin
            st_nxt.ph = st_r.ph + 2'h1;
            if (st_r.ph == 2'h0) begin
               st_nxt.pins.re_n = 1'b0;
            end else if (st_r.ph == PH_RD_LAST) begin
               st_nxt.pins.re_n = 1'b1;
               st_nxt.rd_data   = pins_s[7:0];
               st_nxt.rd_valid  = 1'b1;
               st_nxt.cnt       = st_r.cnt + 12'h001;
               if (st_r.cnt == rlen - 12'h001) begin            // [R18] [R19]
                  st_nxt.done = 1'b1;
                  st_nxt.fsm  = S_IDLE;
               end
            end
         end
         default: st_nxt.fsm = S_IDLE;
      endcase
      st_nxt.pins.ce_n = (st_nxt.fsm == S_IDLE);
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign req_ready_o = (st_r.fsm == S_IDLE);
   assign wr_ready_o  = (st_r.fsm == S_DATA) && (st_r.ph == 2'h0);
   assign rd_data_o   = st_r.rd_data;
   assign rd_valid_o  = st_r.rd_valid;
   assign done_o      = st_r.done;
   assign rej_o       = st_r.rej;
   assign tmo_o       = st_r.tmo;
   assign init_done_o = st_r.init_done;
   assign id_mode_o   = st_r.id_mode;
   assign nand_pins_o = st_r.pins;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   property p_first_reset;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (!st_r.init_done && st_r.fsm == S_CMD && st_r.ph == 2'h1)
         |-> st_r.pins.io_out == C_RESET;
   endproperty
   a_first_reset: assert property (p_first_reset) // [R14]
      else $error("command other than reset before init");

   property p_ecc_refuse;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (st_r.fsm == S_IDLE && req_valid_i && ecc_en_i && two_plane(req_i.op))
         |=> rej_o && st_r.fsm == S_IDLE;
   endproperty
   a_ecc_refuse: assert property (p_ecc_refuse) // [R8]
      else $error("two-plane op issued with ecc on");

   property p_rand_refuse;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (st_r.fsm == S_IDLE && req_valid_i && req_i.op == OP_RAND2 &&
       !st_r.rd2_done) |=> rej_o;
   endproperty
   a_rand_refuse: assert property (p_rand_refuse) // [R4]
      else $error("random read without two-plane read");

   property p_id_idle;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (st_r.fsm == S_IDLE && req_valid_i && is_id(req_i.op) && !rdy)
         |=> rej_o;
   endproperty
   a_id_idle: assert property (p_id_idle) // [R16]
      else $error("identifier read issued while busy");

   property p_reset_tmo;
      @(posedge mclk_i) disable iff (sys_rst_i)
      $rose(tmo_o) |-> $past(st_r.tmr) == 16'(RST_TMO_CYC - 1);
   endproperty
   a_reset_tmo: assert property (p_reset_tmo) // [R15]
      else $error("reset timeout at wrong count");

   property p_reset_clear;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (st_r.fsm == S_BUSY && st_r.req.op == OP_RESET && rdy)
         |=> !st_r.rd2_done && !st_r.mv_ok && st_r.init_done && done_o;
   endproperty
   a_reset_clear: assert property (p_reset_clear) // [R11]
      else $error("flags not cleared after reset");

   property p_id_mode;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (issue && !is_id(req_i.op)) |=> !st_r.id_mode;
   endproperty
   a_id_mode: assert property (p_id_mode) // [R17]
      else $error("identifier mode kept after new command");

   property p_wait_ready;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (st_r.fsm == S_PRE && !rdy) |=> st_r.fsm == S_PRE && st_r.pins.we_n;
   endproperty
   a_wait_ready: assert property (p_wait_ready) // [R1]
      else $error("command written to busy device");

   property p_erase_nod1;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (st_r.req.op == OP_ER2_NOD1 && st_r.fsm == S_CMD && st_r.ph == 2'h1)
         |-> st_r.pins.io_out != C_ERASE_NXT;
   endproperty
   a_erase_nod1: assert property (p_erase_nod1) // [R7]
      else $error("intermediate erase command sent");

endmodule : nand_two_plane_host
`default_nettype wire

// ===== testbench/nand_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model
   import nand_host_pkg::*;
#(
   parameter int         BUSY = 30,
   parameter logic [7:0] MFR  = 8'h5a   // arbitrary maker code
)(
   input  wire logic       mclk_i,
   input  wire pins_t      p_i,
   output logic      [7:0] io_o,
   output logic            rb_o
);
   int         ncmd = 0;
   int         nadr = 0;
   int         bcnt = 0;
   int         idx  = 0;
   logic [7:0] stat = 8'h00;
   logic [7:0] lastc = 8'h00;
   logic [7:0] alt  = 8'h00;
   logic       we_q = 1'b1;
   logic       re_q = 1'b1;
   logic       sig  = 1'b0;
   logic       idm  = 1'b0;
   // latch cycles on the we_n rise, run busy time, step the read index
   always @(posedge mclk_i) begin
      we_q <= p_i.we_n;
      re_q <= p_i.re_n;
      alt  <= ~io_o;
      if (bcnt > 0) bcnt <= bcnt - 1;
      if (!re_q && p_i.re_n) idx <= idx + 1;
      if (!we_q && p_i.we_n && p_i.cle) begin
         ncmd  <= ncmd + 1;
         lastc <= p_i.io_out;
         idm   <= (p_i.io_out == 8'h90);
         idx   <= 0;
         if (p_i.io_out == 8'hff) stat <= p_i.wp_n ? 8'he0 : 8'h60;
         if (p_i.io_out inside {8'hff, 8'h30, 8'h35, 8'h10, 8'h15, 8'hd0})
            bcnt <= BUSY;
      end
      if (!we_q && p_i.we_n && p_i.ale) begin
         nadr <= nadr + 1;
         sig  <= (p_i.io_out == 8'h20);
      end
   end
   // ready line and read data; unselected bus shows a changing pattern
   assign rb_o = (bcnt == 0);
   assign io_o = (p_i.ce_n || p_i.re_n) ? alt : !idm ? 8'(idx) :
                 sig ? 8'(32'h49464e4f >> (8 * idx)) :
                 (idx == 0) ? MFR : 8'h90;
endmodule : nand_dev_model
`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
   import nand_host_pkg::*;
;
   localparam logic [7:0] MFR_ID = 8'h5a;  // arbitrary maker code
   logic mclk_i = 0, sys_rst_i = 1, req_valid_i = 0, ecc_en_i = 0;
   logic wr_protect_i = 0, wr_valid_i = 1, wr_last_i = 1, rb;
   logic req_ready_o, wr_ready_o, rd_valid_o, done_o, rej_o, tmo_o;
   logic init_done_o, id_mode_o;
   logic [7:0]  wr_data_i = 8'h00, io, rd_data_o;
   logic [39:0] ad0, ad1;
   logic [31:0] seed = 54;
   req_t        req_i = '0;
   pins_t       pins;
   int          n_mismatch = 0, n_compared = 0, n_wr = 0;
   logic [7:0]  rb_q[$];
   op_t ops[14] = '{OP_ID_MAIN, OP_ID_SIG, OP_RAND2, OP_RD2, OP_RAND2,
      OP_PG2, OP_PG2, OP_PG2_CACHE, OP_PG2_MV, OP_ER2, OP_ER2_NOD1,
      OP_RD2_MV, OP_PG2_MV, OP_RESET};
   logic [13:0] eccv = 14'h0020, rejv = 14'h0124;
   nand_two_plane_host #(.RST_TMO_CYC(200)) i_nand_two_plane_host (
      .mclk_i, .sys_rst_i, .req_valid_i, .req_i, .req_ready_o, .ecc_en_i,
      .wr_protect_i, .wr_data_i, .wr_valid_i, .wr_last_i, .wr_ready_o,
      .rd_data_o, .rd_valid_o, .done_o, .rej_o, .tmo_o, .init_done_o,
      .id_mode_o, .nand_pins_o(pins), .io_i(io), .rdy_busy_n_i(rb));
   nand_dev_model #(.BUSY(30), .MFR(MFR_ID)) i_nand_dev_model (
      .mclk_i, .p_i(pins), .io_o(io), .rb_o(rb));
   // clock, data stream and read capture
   always #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i) wr_data_i <= wr_data_i + 8'h01;
   always @(negedge mclk_i) if (rd_valid_o === 1'b1) rb_q.push_back(rd_data_o);
   always @(posedge mclk_i) if (wr_ready_o && wr_valid_i) n_wr <= n_wr + 1;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // command count, address count and final command of each sequence
   function automatic logic [15:0] exp_seq(op_t o);
      case (o)
         OP_RD2:       return 16'h3a30;
         OP_RD2_MV:    return 16'h3a35;
         OP_RAND2:     return 16'h25e0;
         OP_PG2, OP_PG2_MV: return 16'h4a10;
         OP_PG2_CACHE: return 16'h4a15;
         OP_ER2:       return 16'h46d0;
         OP_ER2_NOD1:  return 16'h36d0;
         OP_RESET:     return 16'h10ff;
         default:      return 16'h1190;
      endcase
   endfunction : exp_seq
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conclude();
      if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   // one request through the handshake, then judge the device traffic
   task automatic run(input op_t o, input logic ecc, input logic rej);
      int c0, a0, nb, w0;
      logic r, t;
      logic [15:0] e;
      @(posedge mclk_i);
      c0 = i_nand_dev_model.ncmd;
      a0 = i_nand_dev_model.nadr;
      w0 = n_wr;
      rb_q = {};
      e = exp_seq(o);
      if (o != OP_PG2_MV) ad0 = 40'({rnd(), rnd()});
      if (o != OP_PG2_MV) ad1 = 40'({rnd(), rnd()});
      ecc_en_i <= ecc;
      wr_protect_i <= rnd() % 2;
      req_i <= '{o, ad0, ad1, 12'(rnd() % 8 + 1), 1'b1};
      req_valid_i <= 1'b1;
      do @(negedge mclk_i); while (req_ready_o !== 1'b1);
      @(posedge mclk_i);
      req_valid_i <= 1'b0;
      do @(negedge mclk_i); while (!done_o && !rej_o && !tmo_o);
      r = rej_o;
      t = tmo_o;
      @(posedge mclk_i);
      check(r, rej);
      check(t, 1'b0);
      if (!rej) begin
         check(i_nand_dev_model.ncmd - c0, e[15:12]);
         check(i_nand_dev_model.nadr - a0, e[11:8]);
         check(i_nand_dev_model.lastc, e[7:0]);
         check(id_mode_o, o inside {OP_ID_MAIN, OP_ID_SIG});
         nb = o == OP_RAND2 ? req_i.rd_len : o == OP_ID_MAIN ? 5 :
              o == OP_ID_SIG ? 4 : 0;
         check(rb_q.size(), nb);
         check(n_wr - w0, o inside {[OP_PG2:OP_PG2_MV]} ? 2 : 0);
         if (o == OP_RAND2) foreach (rb_q[i]) check(rb_q[i], i);
         if (o == OP_ID_MAIN) check(rb_q[0], MFR_ID);
         if (o == OP_ID_SIG) foreach (rb_q[i])
            check(rb_q[i], 8'(32'h49464e4f >> (8 * i)));
         if (o == OP_RESET)
            check(i_nand_dev_model.stat, {~wr_protect_i, 7'h60});
      end
   endtask : run
   // reset, power-on sequence, then the table of requests
   initial begin
      repeat (16) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      do @(negedge mclk_i); while (init_done_o !== 1'b1);
      check(i_nand_dev_model.ncmd, 1);
      check(i_nand_dev_model.lastc, 8'hff);
      foreach (ops[i]) run(ops[i], eccv[i], rejv[i]);
      conclude();
   end
   // watchdog against a hung handshake
   initial begin
      repeat (40000) @(posedge mclk_i);
      n_mismatch++;
      conclude();
   end
endmodule : testbench
`default_nettype wire
